// ==== shared/lcep_pkg.sv ====
package lcep_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and register map

   localparam int AXI_ADDR_W = 12;
   localparam int IDX_W = AXI_ADDR_W - 2;

   // Register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DUTY_G2 = 10'h034;
   localparam logic [IDX_W-1:0] IDX_DUTY_H0 = 10'h035;
   localparam logic [IDX_W-1:0] IDX_DUTY_H1 = 10'h036;
   localparam logic [IDX_W-1:0] IDX_DUTY_H2 = 10'h037;
   localparam logic [IDX_W-1:0] IDX_EN_AB = 10'h040;
   localparam logic [IDX_W-1:0] IDX_EN_CD = 10'h041;
   localparam logic [IDX_W-1:0] IDX_EN_EF = 10'h042;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] DUTY_LSB_MASK = 8'h0F;
   localparam logic [7:0] EN_MASK = 8'h77;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // PWM timing

   localparam int DUTY_W = 12;
   localparam int DUTY_HI_W = 8;
   localparam int DUTY_CH = 4;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PWM_TICK_NS = 200;
   localparam int PWM_TICK_CYCLES =
      (PWM_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;
   localparam logic [DUTY_W-1:0] COUNT_RESET = 12'h000;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers

   typedef struct packed {
      logic chan_on_f2;
      logic chan_on_f1;
      logic chan_on_f0;
      logic chan_on_e2;
      logic chan_on_e1;
      logic chan_on_e0;
      logic chan_on_d2;
      logic chan_on_d1;
      logic chan_on_d0;
      logic chan_on_c2;
      logic chan_on_c1;
      logic chan_on_c0;
      logic chan_on_b2;
      logic chan_on_b1;
      logic chan_on_b0;
      logic chan_on_a2;
      logic chan_on_a1;
      logic chan_on_a0;
   } lcep_chan_on_t;

   // Entry 0 is G2, then H0, H1, H2
   typedef logic [DUTY_CH-1:0][DUTY_W-1:0] lcep_duty_full_t;
   typedef logic [DUTY_CH-1:0][DUTY_HI_W-1:0] lcep_duty_high_t;

   typedef struct packed {
      logic [IDX_W-1:0] wr_idx;
      logic wr_idx_held;
      logic [7:0] wr_data;
      logic wr_lane0;
      logic wr_data_held;
      logic b_valid;
      logic [1:0] b_resp;
      logic r_valid;
      logic [7:0] r_data;
      logic [1:0] r_resp;
      logic [3:0] duty_lsb_field_g2;
      logic [3:0] duty_lsb_field_h0;
      logic [3:0] duty_lsb_field_h1;
      logic [3:0] duty_lsb_field_h2;
      logic [7:0] channel_enable_group_ab;
      logic [7:0] channel_enable_group_cd;
      logic [7:0] channel_enable_group_ef;
      logic [7:0] pwm_prescale;
      logic [DUTY_W-1:0] pwm_count;
      logic [DUTY_CH-1:0] pwm_gh;
      logic [17:0] pwm_af;
   } lcep_state_t;

   localparam lcep_state_t STATE_RESET = '0;

endpackage : lcep_pkg

// ==== logic/lcep_regs.sv ====
// How it works
// - Four registers 34h-37h hold writable 4-bit duty low parts for G2, H0-H2.
// - Upper four bits of each duty low register read zero; writes ignored.
// - Register 40h: A0-A2 in bits 0-2, B0-B2 in bits 4-6, others zero.
// - Register 41h: C0-C2 in bits 0-2, D0-D2 in bits 4-6, others zero.
// - Register 42h: E0-E2 in bits 0-2, F0-F2 in bits 4-6, others zero.
// - Enable bits read/write; 0 keeps the output off, 1 lets it run.
// - Reset loads 00h into every register of this block.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module lcep_regs #(
   parameter int PWM_DIV = lcep_pkg::PWM_TICK_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // AXI4-Lite write address
   input wire logic [lcep_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [lcep_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Upper duty bits and enables for G2..H2, from same-clock logic
   input wire lcep_pkg::lcep_duty_high_t duty_high,
   input wire logic [lcep_pkg::DUTY_CH-1:0] gh_chan_on,
   // Raw PWM of channels A0..F2, from same-clock logic
   input wire logic [17:0] pwm_af_raw,
   // Channel state out
   output lcep_pkg::lcep_chan_on_t chan_on,
   output lcep_pkg::lcep_duty_full_t duty_full,
   output logic [lcep_pkg::DUTY_CH-1:0] pwm_gh_out,
   output logic [17:0] pwm_af_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   lcep_pkg::lcep_state_t state;
   lcep_pkg::lcep_state_t next_state;

   logic aw_take;
   logic w_take;
   logic ar_take;
   logic wr_commit;
   logic [lcep_pkg::IDX_W-1:0] wr_idx_eff;
   logic [7:0] wr_data_eff;
   logic wr_lane0_eff;
   logic [lcep_pkg::IDX_W-1:0] rd_idx;
   logic [lcep_pkg::DUTY_CH-1:0][3:0] duty_lsb_all;
   logic [lcep_pkg::DUTY_CH-1:0] duty_cmp;
   logic pwm_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic idx_mapped(
      input logic [lcep_pkg::IDX_W-1:0] idx
   );
      idx_mapped = (idx == lcep_pkg::IDX_DUTY_G2) ||
         (idx == lcep_pkg::IDX_DUTY_H0) ||
         (idx == lcep_pkg::IDX_DUTY_H1) ||
         (idx == lcep_pkg::IDX_DUTY_H2) ||
         (idx == lcep_pkg::IDX_EN_AB) ||
         (idx == lcep_pkg::IDX_EN_CD) ||
         (idx == lcep_pkg::IDX_EN_EF);
   endfunction : idx_mapped

   // Reserved bits are masked here, so they read zero whatever was written
   function automatic logic [7:0] read_reg(
      input lcep_pkg::lcep_state_t s,
      input logic [lcep_pkg::IDX_W-1:0] idx
   );
      read_reg = 8'h00;
      if (idx == lcep_pkg::IDX_DUTY_G2)
      begin
         read_reg = {4'h0, s.duty_lsb_field_g2};
      end
      else if (idx == lcep_pkg::IDX_DUTY_H0)
      begin
         read_reg = {4'h0, s.duty_lsb_field_h0};
      end
      else if (idx == lcep_pkg::IDX_DUTY_H1)
      begin
         read_reg = {4'h0, s.duty_lsb_field_h1};
      end
      else if (idx == lcep_pkg::IDX_DUTY_H2)
      begin
         read_reg = {4'h0, s.duty_lsb_field_h2};
      end
      else if (idx == lcep_pkg::IDX_EN_AB)
      begin
         read_reg = s.channel_enable_group_ab & lcep_pkg::EN_MASK;
      end
      else if (idx == lcep_pkg::IDX_EN_CD)
      begin
         read_reg = s.channel_enable_group_cd & lcep_pkg::EN_MASK;
      end
      else if (idx == lcep_pkg::IDX_EN_EF)
      begin
         read_reg = s.channel_enable_group_ef & lcep_pkg::EN_MASK;
      end
   endfunction : read_reg

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes

   // No new address or data while a response waits, so one write at a time
   assign s_axi_awready = !state.wr_idx_held && !state.b_valid;
   assign s_axi_wready = !state.wr_data_held && !state.b_valid;
   assign s_axi_arready = !state.r_valid;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   assign wr_idx_eff = state.wr_idx_held ? state.wr_idx :
      s_axi_awaddr[lcep_pkg::AXI_ADDR_W-1:2];
   assign wr_data_eff = state.wr_data_held ? state.wr_data :
      s_axi_wdata[7:0];
   assign wr_lane0_eff = state.wr_data_held ? state.wr_lane0 :
      s_axi_wstrb[0];
   assign wr_commit = (state.wr_idx_held || aw_take) &&
      (state.wr_data_held || w_take);
   assign rd_idx = s_axi_araddr[lcep_pkg::AXI_ADDR_W-1:2];

   assign s_axi_bvalid = state.b_valid;
   assign s_axi_bresp = state.b_resp;
   assign s_axi_rvalid = state.r_valid;
   assign s_axi_rresp = state.r_resp;
   assign s_axi_rdata = {24'h000000, state.r_data};

   ////////////////////////////////////////////////////////////////////////////
   // Duty assembly and compare per channel

   assign duty_lsb_all = {state.duty_lsb_field_h2, state.duty_lsb_field_h1,
      state.duty_lsb_field_h0, state.duty_lsb_field_g2};

   genvar ch;
   generate
      for (ch = 0; ch < lcep_pkg::DUTY_CH; ch++)
      begin : g_duty
         assign duty_full[ch] = {duty_high[ch], duty_lsb_all[ch]};
         assign duty_cmp[ch] = state.pwm_count < duty_full[ch];
      end
   endgenerate

   assign pwm_tick = state.pwm_prescale == 8'(PWM_DIV - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Enable bits in channel order, A0 in bit 0 up to F2 in bit 17

   logic [2:0][7:0] en_grp;
   logic [17:0] en_af;

   assign en_grp = {state.channel_enable_group_ef,
      state.channel_enable_group_cd, state.channel_enable_group_ab};

   genvar grp;
   generate
      for (grp = 0; grp < 3; grp++)
      begin : g_en_grp
         // Bits 3 and 7 are reserved and never reach a channel
         assign en_af[6*grp+2 -: 3] = en_grp[grp][2:0];
         assign en_af[6*grp+5 -: 3] = en_grp[grp][6:4];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_state = state;

      // Write address and data may arrive in either order
      if (aw_take && !wr_commit)
      begin
         next_state.wr_idx = s_axi_awaddr[lcep_pkg::AXI_ADDR_W-1:2];
         next_state.wr_idx_held = 1'b1;
      end
      if (w_take && !wr_commit)
      begin
         next_state.wr_data = s_axi_wdata[7:0];
         next_state.wr_lane0 = s_axi_wstrb[0];
         next_state.wr_data_held = 1'b1;
      end

      if (wr_commit)
      begin
         next_state.wr_idx_held = 1'b0;
         next_state.wr_data_held = 1'b0;
         next_state.b_valid = 1'b1;
         next_state.b_resp = idx_mapped(wr_idx_eff) ?
            lcep_pkg::RESP_OKAY : lcep_pkg::RESP_SLVERR;
         // Only lane 0 carries the register; other lanes have no bits
         if (wr_lane0_eff)
         begin
            unique case (wr_idx_eff)
               lcep_pkg::IDX_DUTY_G2:
               begin
                  next_state.duty_lsb_field_g2 = wr_data_eff[3:0];
               end
               lcep_pkg::IDX_DUTY_H0:
               begin
                  next_state.duty_lsb_field_h0 = wr_data_eff[3:0];
               end
               lcep_pkg::IDX_DUTY_H1:
               begin
                  next_state.duty_lsb_field_h1 = wr_data_eff[3:0];
               end
               lcep_pkg::IDX_DUTY_H2:
               begin
                  next_state.duty_lsb_field_h2 = wr_data_eff[3:0];
               end
               lcep_pkg::IDX_EN_AB:
               begin
                  next_state.channel_enable_group_ab =
                     wr_data_eff & lcep_pkg::EN_MASK;
               end
               lcep_pkg::IDX_EN_CD:
               begin
                  next_state.channel_enable_group_cd =
                     wr_data_eff & lcep_pkg::EN_MASK;
               end
               lcep_pkg::IDX_EN_EF:
               begin
                  next_state.channel_enable_group_ef =
                     wr_data_eff & lcep_pkg::EN_MASK;
               end
               default:
               begin
                  next_state.b_resp = lcep_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
      else if (state.b_valid && s_axi_bready)
      begin
         next_state.b_valid = 1'b0;
      end

      if (ar_take)
      begin
         next_state.r_valid = 1'b1;
         next_state.r_data = read_reg(state, rd_idx);
         next_state.r_resp = idx_mapped(rd_idx) ?
            lcep_pkg::RESP_OKAY : lcep_pkg::RESP_SLVERR;
      end
      else if (state.r_valid && s_axi_rready)
      begin
         next_state.r_valid = 1'b0;
      end

      // Free-running period counter, one step per prescaler tick
      if (pwm_tick)
      begin
         next_state.pwm_prescale = lcep_pkg::PRESCALE_RESET;
         next_state.pwm_count = state.pwm_count + 12'h001;
      end
      else
      begin
         next_state.pwm_prescale = state.pwm_prescale + 8'h01;
      end

      // Duty 0 never pulses; full scale stays low one count per period
      next_state.pwm_gh = duty_cmp & gh_chan_on;
      // A disabled channel stays low whatever its raw PWM does
      next_state.pwm_af = pwm_af_raw & en_af;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= lcep_pkg::STATE_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   always_comb
   begin
      chan_on = '0;
      chan_on.chan_on_a0 = state.channel_enable_group_ab[0];
      chan_on.chan_on_a1 = state.channel_enable_group_ab[1];
      chan_on.chan_on_a2 = state.channel_enable_group_ab[2];
      chan_on.chan_on_b0 = state.channel_enable_group_ab[4];
      chan_on.chan_on_b1 = state.channel_enable_group_ab[5];
      chan_on.chan_on_b2 = state.channel_enable_group_ab[6];
      chan_on.chan_on_c0 = state.channel_enable_group_cd[0];
      chan_on.chan_on_c1 = state.channel_enable_group_cd[1];
      chan_on.chan_on_c2 = state.channel_enable_group_cd[2];
      chan_on.chan_on_d0 = state.channel_enable_group_cd[4];
      chan_on.chan_on_d1 = state.channel_enable_group_cd[5];
      chan_on.chan_on_d2 = state.channel_enable_group_cd[6];
      chan_on.chan_on_e0 = state.channel_enable_group_ef[0];
      chan_on.chan_on_e1 = state.channel_enable_group_ef[1];
      chan_on.chan_on_e2 = state.channel_enable_group_ef[2];
      chan_on.chan_on_f0 = state.channel_enable_group_ef[4];
      chan_on.chan_on_f1 = state.channel_enable_group_ef[5];
      chan_on.chan_on_f2 = state.channel_enable_group_ef[6];
   end

   assign pwm_gh_out = state.pwm_gh;
   assign pwm_af_out = state.pwm_af;

endmodule : lcep_regs

// ==== verification/lcep_regs_sva.sv ====
`timescale 1ns/1ps
module lcep_regs_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // Channel side
   input wire lcep_pkg::lcep_duty_high_t duty_high,
   input wire logic [lcep_pkg::DUTY_CH-1:0] gh_chan_on,
   input wire logic [17:0] pwm_af_raw,
   input wire lcep_pkg::lcep_chan_on_t chan_on,
   input wire lcep_pkg::lcep_duty_full_t duty_full,
   input wire logic [lcep_pkg::DUTY_CH-1:0] pwm_gh_out,
   input wire logic [17:0] pwm_af_out
);
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
sequence s_wr_pair;
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_wr_answer;
   s_axi_bvalid ##1 !s_axi_bvalid;
endsequence
property p_wr_answer;
   s_wr_pair |=> s_wr_answer;
endproperty
a_wr_answer: assert property (p_wr_answer)
   else $error("write response not one cycle after the pair");
property p_rd_answer;
   s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid;
endproperty
a_rd_answer: assert property (p_rd_answer)
   else $error("read data not one cycle after the address");
property p_rd_upper;
   s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
endproperty
a_rd_upper: assert property (p_rd_upper)
   else $error("read data upper bits not zero");
property p_refused;
   s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
endproperty
a_refused: assert property (p_refused)
   else $error("write channel open while response pending");
property p_reset_clear;
   $fell(sys_rst) |-> chan_on == '0 && !s_axi_bvalid && !s_axi_rvalid;
endproperty
a_reset_clear: assert property (p_reset_clear)
   else $error("state not cleared by reset");
// Enables move only as the result of a bus write
property p_en_by_write;
   $changed(chan_on) |-> $rose(s_axi_bvalid);
endproperty
a_en_by_write: assert property (p_en_by_write)
   else $error("enable changed without a write");
property p_af_gate;
   !$past(sys_rst) |-> pwm_af_out == ($past(pwm_af_raw) & $past(chan_on));
endproperty
a_af_gate: assert property (p_af_gate)
   else $error("channel output not gated by its enable");
property p_gh_gate;
   !$past(sys_rst) |-> (pwm_gh_out & ~$past(gh_chan_on)) == 4'h0;
endproperty
a_gh_gate: assert property (p_gh_gate)
   else $error("disabled channel output pulses");
property p_duty_join;
   {duty_full[3][11:4], duty_full[2][11:4], duty_full[1][11:4],
      duty_full[0][11:4]} == duty_high;
endproperty
a_duty_join: assert property (p_duty_join)
   else $error("upper duty bits not joined");
endmodule : lcep_regs_sva

// ==== verification/test_lcep_regs.sv ====
`timescale 1ns/1ps
module test_lcep_regs;
logic core_clk = 1'h0;
logic sys_rst = 1'h1;
logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'hF, gh_chan_on = 4'h5, pwm_gh_out;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp;
lcep_pkg::lcep_duty_high_t duty_high = 32'h78563412;
logic [17:0] pwm_af_raw = 18'h3FFFF, pwm_af_out, exp_on;
lcep_pkg::lcep_chan_on_t chan_on;
lcep_pkg::lcep_duty_full_t duty_full;
int errors = 0, checks_done = 0;
localparam logic [1:0] OK = lcep_pkg::RESP_OKAY;
localparam logic [1:0] BAD = lcep_pkg::RESP_SLVERR;
logic [9:0] idx_tab [7] = '{lcep_pkg::IDX_DUTY_G2, lcep_pkg::IDX_DUTY_H0,
   lcep_pkg::IDX_DUTY_H1, lcep_pkg::IDX_DUTY_H2, lcep_pkg::IDX_EN_AB,
   lcep_pkg::IDX_EN_CD, lcep_pkg::IDX_EN_EF};
// Short prescaler keeps the counter busy within a short run
lcep_regs #(.PWM_DIV(1)) dut (.core_clk, .sys_rst, .s_axi_awaddr,
   .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duty_high,
   .gh_chan_on, .pwm_af_raw, .chan_on, .duty_full, .pwm_gh_out, .pwm_af_out);
always #25 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
   if (errors == 0 && checks_done > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
endtask : wrap_up
task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
   checks_done++;
   if (got !== exp)
   begin
      errors++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
   end
endtask : cmp
// Every bus handshake wait goes through here so that a hang ends the run
task automatic tick(inout int n);
   @(posedge core_clk);
   n++;
   if (n > 40)
   begin
      errors++;
      $display("unexpected %0t bus handshake timed out", $time);
      wrap_up();
   end
endtask : tick
task automatic wr(input logic [9:0] ix, input logic [31:0] d,
   input logic [3:0] st, input logic [1:0] exp_resp);
   int n = 0;
   logic aw_p = 1'h1;
   logic w_p = 1'h1;
   s_axi_awaddr <= {ix, 2'h0};
   s_axi_wdata <= d;
   s_axi_wstrb <= st;
   s_axi_awvalid <= 1'h1;
   s_axi_wvalid <= 1'h1;
   while (aw_p || w_p)
   begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      aw_p = aw_p && !s_axi_awready;
      w_p = w_p && !s_axi_wready;
   end
   while (!s_axi_bvalid)
      tick(n);
   cmp(32'(s_axi_bresp), 32'(exp_resp));
endtask : wr
task automatic rd(input logic [9:0] ix, input logic [31:0] exp,
   input logic [1:0] exp_resp);
   int n = 0;
   logic ar_p = 1'h1;
   s_axi_araddr <= {ix, 2'h0};
   s_axi_arvalid <= 1'h1;
   while (ar_p)
   begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      ar_p = !s_axi_arready;
   end
   while (!s_axi_rvalid)
      tick(n);
   cmp(s_axi_rdata, exp);
   cmp(32'(s_axi_rresp), 32'(exp_resp));
endtask : rd
task automatic all_clear;
   for (int i = 0; i < 7; i++)
      rd(idx_tab[i], 32'h0, OK);
   cmp(32'(chan_on), 32'h0);
   cmp(32'(pwm_af_out), 32'h0);
endtask : all_clear
////////////////////////////////////////////////////////////////////////////////
initial
begin
   repeat (10) @(posedge core_clk);
   sys_rst <= 1'h0;
   @(posedge core_clk);
   all_clear();
   for (int i = 0; i < 4; i++)
   begin
      wr(idx_tab[i], {28'hFFFFFFF, 4'(i + 3)}, 4'hF, OK);
      rd(idx_tab[i], 32'(i + 3), OK);
      cmp(32'(duty_full[i]), 32'({duty_high[i], 4'(i + 3)}));
   end
   // Lane 0 strobe off leaves the register alone
   wr(idx_tab[0], 32'hFFFFFFFF, 4'hE, OK);
   rd(idx_tab[0], 32'h3, OK);
   for (int k = 0; k < 3; k++)
      for (int b = 0; b < 8; b++)
      begin
         pwm_af_raw <= b[0] ? 18'h2AAAA : 18'h3FFFF;
         wr(idx_tab[4 + k], 32'h1 << b, 4'hF, OK);
         rd(idx_tab[4 + k], 32'h77 & (32'h1 << b), OK);
         exp_on = (b == 3 || b == 7) ? 18'h0 :
            18'h1 << (6 * k + b - (b > 3 ? 1 : 0));
         cmp(32'(chan_on), 32'(exp_on));
         repeat (2) @(posedge core_clk);
         cmp(32'(pwm_af_out), 32'(exp_on & pwm_af_raw));
      end
   for (int k = 0; k < 3; k++)
   begin
      wr(idx_tab[4 + k], 32'hFFFFFFFF, 4'hF, OK);
      rd(idx_tab[4 + k], 32'h77, OK);
   end
   cmp(32'(chan_on), 32'h3FFFF);
   gh_chan_on <= 4'h0;
   repeat (3) @(posedge core_clk);
   cmp(32'(pwm_gh_out), 32'h0);
   wr(10'h033, 32'hFF, 4'hF, BAD);
   rd(10'h033, 32'h0, BAD);
   wr(10'h043, 32'hFF, 4'hF, BAD);
   rd(idx_tab[6], 32'h77, OK);
   // Second reset in mid-run must clear everything again
   sys_rst <= 1'h1;
   gh_chan_on <= 4'hA;
   repeat (2) @(posedge core_clk);
   sys_rst <= 1'h0;
   @(posedge core_clk);
   all_clear();
   // Counter is far below every full duty this soon after reset
   cmp(32'(pwm_gh_out), 32'hA);
   wrap_up();
end
endmodule : test_lcep_regs
bind lcep_regs lcep_regs_sva u_sva (.core_clk, .sys_rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .duty_high, .gh_chan_on, .pwm_af_raw, .chan_on,
   .duty_full, .pwm_gh_out, .pwm_af_out);
